// >>> logic/fp_voter_pkg.sv
package fp_voter_pkg;

	// register byte offsets on the avalon slave (word aligned)
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam logic [3:0] OFS_EVENT   = 4'h8;
	localparam logic [3:0] OFS_FLASH   = 4'hC;

	// ctrl register fields
	localparam int CTRL_USER1  = 0;
	localparam int CTRL_USER2  = 1;
	localparam int CTRL_IRQCLR = 2;
	localparam int CTRL_LOGCLR = 3;

	// status word from each slice
	localparam int SW_WIDTH    = 16;
	localparam int SW_ACTIVE   = 0;
	localparam int SW_STANDBY  = 1;
	localparam int SW_EDU_DONE = 2;
	localparam int SW_EDU_BUSY = 3;
	localparam int SW_APP_RUN  = 4;
	localparam int SW_FULL_INT = 5;
	localparam int SW_IO_LOCK  = 6;
	localparam int SW_CFG_DIFF = 7;
	localparam int SW_CO_TRY   = 8;
	localparam int SW_SYS_OK   = 9;
	localparam int SW_SYS_FLT  = 10;
	localparam int SW_ILLEGAL  = 11;
	localparam int SW_HLT_FAIL = 12;

	// flash divider: 40 MHz core clock, half period in cycles
	localparam int          CLK_HZ            = 40_000_000;
	localparam int          FLASH_HALF_MS     = 250;
	localparam logic [31:0] FLASH_HALF_CYCLES = 32'(CLK_HZ / 1000 * FLASH_HALF_MS);

	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAP  = 32'h0000_0000;

endpackage

// >>> logic/front_panel_voter_unit.sv
// What this block does
// - drives twelve front panel lamps
// - two-of-three vote every slice status bit
// - slice health lamps driven directly, unvoted
// - active lamp green only when active
// - standby lamp green when in standby
// - educated lamp steady, flashing, or off
// - run lamp flashes, steady standby, off stopped
// - inhibit flashes on io lock or on config mismatch during a changeover try
// - system lamp green, flash red, off illegal
// - user lamps red, software only
// - latch switch raises interrupt to every processor
// - active ejector open starts changeover
// - failing slice moves processing to standby
// - only the active module starts changeover
// - every changeover logged as event
// - standby keeps diagnostics, accepts state updates
// - watchdog indication from voted watchdog
`timescale 1ns/100ps
`default_nettype none

module front_panel_voter_unit
	import fp_voter_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	// slice status words and their shared valid strobe
	input  wire logic [SW_WIDTH-1:0] slice_a_status,
	input  wire logic [SW_WIDTH-1:0] slice_b_status,
	input  wire logic [SW_WIDTH-1:0] slice_c_status,
	input  wire logic                status_valid,
	input  wire logic [2:0]          slice_healthy,
	input  wire logic [2:0]          slice_watchdog,
	input  wire logic                latch_top_open,
	input  wire logic                latch_bottom_open,
	input  wire logic                ejector_open,
	// avalon-mm slave
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// lamps: green and red drive per bicolour lamp
	output logic      [2:0]          led_health_green,
	output logic      [2:0]          led_health_red,
	output logic                     led_active,
	output logic                     led_standby,
	output logic                     led_educated,
	output logic                     led_run,
	output logic                     led_inhibit,
	output logic                     led_sys_green,
	output logic                     led_sys_red,
	output logic                     led_user1,
	output logic                     led_user2,
	output logic                     led_watchdog,
	output logic      [2:0]          proc_irq,
	output logic                     changeover_req,
	output logic                     standby_update_accept,
	output logic                     event_log_pulse
);

	////////////////////////////////////////////////////////////////////////
	// voting

	logic [SW_WIDTH-1:0] voted;
	logic                wdog_voted;

	assign voted      = (slice_a_status & slice_b_status) |
	                    (slice_a_status & slice_c_status) |
	                    (slice_b_status & slice_c_status);
	assign wdog_voted = (slice_watchdog[0] & slice_watchdog[1]) |
	                    (slice_watchdog[0] & slice_watchdog[2]) |
	                    (slice_watchdog[1] & slice_watchdog[2]);

	logic [SW_WIDTH-1:0] status_q;
	logic                seen_q;

	// lamps other than the user lamps stay dark until the first voted word lands
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			status_q <= '0;
			seen_q   <= 1'b0;
		end
		else if (status_valid)
		begin
			status_q <= voted;
			seen_q   <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [31:0] ctrl_q;
	logic [31:0] flash_half_q;
	logic [15:0] event_cnt_q;
	logic        wait_q;
	logic        irq_pend_q;
	logic        co_pulse;

	wire acc     = (avs_read | avs_write) & ~wait_q;
	wire wr_ctrl = acc & avs_write & (avs_address == OFS_CTRL);
	wire wr_flsh = acc & avs_write & (avs_address == OFS_FLASH);

	// one wait state per access so read data come from a flop
	always_ff @(posedge core_clk)
	begin
		if (rst)
			wait_q <= 1'b1;
		else
			wait_q <= ~((avs_read | avs_write) & wait_q);
	end

	assign avs_waitrequest = wait_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else if (wr_ctrl)
		begin
			for (int i = 0; i < 4; i++)
				if (avs_byteenable[i])
					ctrl_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
			ctrl_q[CTRL_IRQCLR] <= 1'b0;
			ctrl_q[CTRL_LOGCLR] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			flash_half_q <= FLASH_HALF_CYCLES;
		else if (wr_flsh)
		begin
			for (int i = 0; i < 4; i++)
				if (avs_byteenable[i])
					flash_half_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
		end
	end

	logic [31:0] rd_d;

	always_comb
	begin
		case (avs_address)
			OFS_CTRL:   rd_d = {30'h0000_0000, ctrl_q[CTRL_USER2], ctrl_q[CTRL_USER1]};
			OFS_STATUS: rd_d = {10'h000, irq_pend_q, seen_q, wdog_voted, slice_healthy,
			                    status_q};
			OFS_EVENT:  rd_d = {16'h0000, event_cnt_q};
			OFS_FLASH:  rd_d = flash_half_q;
			default:    rd_d = READ_UNMAP;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			avs_readdata <= '0;
		else if (avs_read & wait_q)
			avs_readdata <= rd_d;
	end

	////////////////////////////////////////////////////////////////////////
	// flash divider

	logic [31:0] flash_cnt_q;
	logic        blink_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			flash_cnt_q <= '0;
			blink_q     <= 1'b0;
		end
		else if (flash_cnt_q + 32'h1 >= flash_half_q)
		begin
			flash_cnt_q <= '0;
			blink_q     <= ~blink_q;
		end
		else
			flash_cnt_q <= flash_cnt_q + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// lamps

	wire st_active  = status_q[SW_ACTIVE];
	wire st_standby = status_q[SW_STANDBY];
	wire app_run    = status_q[SW_APP_RUN];

	always_ff @(posedge core_clk)
	begin
		if (rst | ~seen_q)
		begin
			led_health_green <= '0;
			led_health_red   <= '0;
			led_active       <= 1'b0;
			led_standby      <= 1'b0;
			led_educated     <= 1'b0;
			led_run          <= 1'b0;
			led_inhibit      <= 1'b0;
			led_sys_green    <= 1'b0;
			led_sys_red      <= 1'b0;
			led_watchdog     <= 1'b0;
		end
		else
		begin
			led_health_green <= slice_healthy;
			led_health_red   <= ~slice_healthy;
			led_active       <= st_active;
			led_standby      <= st_standby;
			if (~app_run)
				led_educated <= 1'b0;
			else if (status_q[SW_EDU_DONE])
				led_educated <= 1'b1;
			else
				led_educated <= status_q[SW_EDU_BUSY] & blink_q;
			if (st_standby)
				led_run <= 1'b1;
			else if (app_run & status_q[SW_FULL_INT])
				led_run <= blink_q;
			else
				led_run <= 1'b0;
			led_inhibit <= (status_q[SW_IO_LOCK] |
			                (status_q[SW_CO_TRY] & status_q[SW_CFG_DIFF])) & blink_q;
			if (status_q[SW_ILLEGAL])
			begin
				led_sys_green <= 1'b0;
				led_sys_red   <= 1'b0;
			end
			else if (status_q[SW_SYS_FLT] | ~status_q[SW_SYS_OK])
			begin
				led_sys_green <= 1'b0;
				led_sys_red   <= blink_q;
			end
			else
			begin
				led_sys_green <= 1'b1;
				led_sys_red   <= 1'b0;
			end
			led_watchdog <= wdog_voted;
		end
	end

	// user lamps answer only to software
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			led_user1 <= 1'b0;
			led_user2 <= 1'b0;
		end
		else
		begin
			led_user1 <= ctrl_q[CTRL_USER1];
			led_user2 <= ctrl_q[CTRL_USER2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// removal interlock and changeover

	logic latch_q;
	wire  latch_now  = latch_top_open | latch_bottom_open;
	wire  latch_rise = latch_now & ~latch_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			latch_q <= 1'b0;
		else
			latch_q <= latch_now;
	end

	// a new switch event wins over a software clear in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (rst)
			irq_pend_q <= 1'b0;
		else if (latch_rise)
			irq_pend_q <= 1'b1;
		else if (wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_IRQCLR])
			irq_pend_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			proc_irq <= '0;
		else
			proc_irq <= {3{irq_pend_q}};
	end

	// a standby module never asks; only the active one hands over
	wire  co_cause = st_active & seen_q &
	                 (ejector_open | status_q[SW_HLT_FAIL]);
	logic co_cause_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			co_cause_q <= 1'b0;
		else
			co_cause_q <= co_cause;
	end

	assign co_pulse = co_cause & ~co_cause_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			changeover_req  <= 1'b0;
			event_log_pulse <= 1'b0;
		end
		else
		begin
			changeover_req  <= co_cause;
			event_log_pulse <= co_pulse;
		end
	end

	// counter saturates rather than wrapping so a flood stays visible
	always_ff @(posedge core_clk)
	begin
		if (rst)
			event_cnt_q <= '0;
		// a changeover in the clearing cycle still counts once
		else if (co_pulse & wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_LOGCLR])
			event_cnt_q <= 16'h0001;
		else if (co_pulse & (event_cnt_q != 16'hFFFF))
			event_cnt_q <= event_cnt_q + 16'h1;
		else if (wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_LOGCLR])
			event_cnt_q <= '0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			standby_update_accept <= 1'b0;
		else
			standby_update_accept <= seen_q & st_standby;
	end

endmodule

`default_nettype wire

// >>> dv/fp_slice_model.sv
`timescale 1ns/100ps
`default_nettype none
module fp_slice_model
	import fp_voter_pkg::*;
(
	input	wire logic			core_clk,
	input	wire logic [SW_WIDTH-1:0]	word,
	input	wire logic [1:0]		bad,
	input	wire logic			send,
	output	logic [SW_WIDTH-1:0]		slice_a_status = '0,
	output	logic [SW_WIDTH-1:0]		slice_b_status = '0,
	output	logic [SW_WIDTH-1:0]		slice_c_status = '0,
	output	logic				status_valid = 1'h0
);
	// slice number bad (1..3) disagrees on every bit, so the vote must mask it
	always @(posedge core_clk)
	begin
		slice_a_status <= bad == 2'h1 ? ~word : word;
		slice_b_status <= bad == 2'h2 ? ~word : word;
		slice_c_status <= bad == 2'h3 ? ~word : word;
		status_valid <= send;
	end
endmodule
`default_nettype wire

// >>> dv/fp_voter_checker_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fp_voter_checker
	import fp_voter_pkg::*;
(
	input	wire logic			core_clk,
	input	wire logic			rst,
	input	wire logic [SW_WIDTH-1:0]	slice_a_status,
	input	wire logic [SW_WIDTH-1:0]	slice_b_status,
	input	wire logic [SW_WIDTH-1:0]	slice_c_status,
	input	wire logic			status_valid,
	input	wire logic [2:0]		slice_healthy,
	input	wire logic			latch_top_open,
	input	wire logic			latch_bottom_open,
	input	wire logic [3:0]		avs_address,
	input	wire logic			avs_read,
	input	wire logic			avs_write,
	input	wire logic			avs_waitrequest,
	input	wire logic [2:0]		led_health_green,
	input	wire logic [2:0]		led_health_red,
	input	wire logic			led_active,
	input	wire logic			led_user1,
	input	wire logic [2:0]		proc_irq,
	input	wire logic			changeover_req,
	input	wire logic			event_log_pulse
);
	logic	[SW_WIDTH-1:0]	vt;
	logic			ctrl_wr;
	assign vt = slice_a_status & slice_b_status | slice_a_status & slice_c_status
		| slice_b_status & slice_c_status;
	assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == OFS_CTRL;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////
	// lag of one or two edges both accepted: only judged once input settled
	property p_health;
		&(led_health_green | led_health_red) && $stable(slice_healthy)
			&& $past(slice_healthy, 2) == slice_healthy
			|-> led_health_green == slice_healthy && led_health_red == ~slice_healthy;
	endproperty
	a_health: assert property (p_health) else $error("health lamp");
	property p_vact;
		status_valid && vt[SW_ACTIVE] |-> ##2 led_active;
	endproperty
	a_vact: assert property (p_vact) else $error("active lamp");
	property p_irq;
		$rose(latch_top_open || latch_bottom_open) |-> ##[1:2] proc_irq == 3'h7;
	endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_irqeq;
		proc_irq == 3'h0 || proc_irq == 3'h7;
	endproperty
	a_irqeq: assert property (p_irqeq) else $error("irq split");
	// an interrupt only ever follows a latch opening two edges earlier
	property p_irqsrc;
		$rose(proc_irq[0]) |-> $past(latch_top_open || latch_bottom_open, 2);
	endproperty
	a_irqsrc: assert property (p_irqsrc) else $error("irq without latch");
	property p_evtco;
		event_log_pulse == $rose(changeover_req);
	endproperty
	a_evtco: assert property (p_evtco) else $error("event not at changeover");
	property p_evt;
		event_log_pulse |=> !event_log_pulse;
	endproperty
	a_evt: assert property (p_evt) else $error("event pulse");
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("wait");
	property p_wpulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wpulse: assert property (p_wpulse) else $error("wait pulse");
	property p_user;
		$changed(led_user1) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
	endproperty
	a_user: assert property (p_user) else $error("user lamp");
	c_evt: cover property (event_log_pulse);
	c_irq: cover property (proc_irq == 3'h7);
	c_rd: cover property (avs_read && !avs_waitrequest);
endmodule
bind front_panel_voter_unit fp_voter_checker u_chk (.*);
`default_nettype wire

// >>> dv/test_front_panel_status_voter.sv
`timescale 1ns/100ps
`default_nettype none
module test_front_panel_status_voter
	import fp_voter_pkg::*;
;
	logic	core_clk = 1'h0, rst = 1'h1, send = 1'h0, status_valid, ejector_open = 1'h0;
	logic	latch_top_open = 1'h0, latch_bottom_open = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic	avs_waitrequest, led_active, led_standby, led_educated, led_run, led_inhibit;
	logic	led_sys_green, led_sys_red, led_user1, led_user2, led_watchdog;
	logic	changeover_req, standby_update_accept, event_log_pulse;
	logic	[SW_WIDTH-1:0]	word = '0, slice_a_status, slice_b_status, slice_c_status;
	logic	[1:0]	bad = '0;
	logic	[2:0]	slice_healthy = 3'h7, slice_watchdog = 3'h7, proc_irq;
	logic	[2:0]	led_health_green, led_health_red;
	logic	[3:0]	avs_address = '0, avs_byteenable = 4'hF;
	logic	[31:0]	avs_writedata = '0, avs_readdata, rdat;
	logic	[6:0]	lamps, lo, la;
	int	bad_count = 0, total_checks = 0, i, pulse_count = 0;
	// per entry: voted word, lamps ever lit, lamps always lit
	localparam logic [15:0] W[4] = '{16'h0235, 16'h0216, 16'h0459, 16'h0985};
	localparam logic [6:0] EO[4] = '{7'h6A, 7'h69, 7'h56, 7'h12};
	localparam logic [6:0] EA[4] = '{7'h4A, 7'h69, 7'h02, 7'h02};
	assign lamps = {led_educated, led_run, led_inhibit, led_sys_green, led_sys_red,
		led_active, led_standby};
	always #12.5 core_clk = ~core_clk;
	fp_slice_model slices (.*);
	front_panel_voter_unit DUT (.*);
	// every changeover must also show as one log pulse on the pin
	always @(posedge core_clk)
		pulse_count <= pulse_count + int'(event_log_pulse === 1'h1);
	////////////////////////////////
	task chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'h0 && ++n < 50);
		rdat = avs_readdata;
		bad_count += int'(n >= 50);
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge core_clk);
	endtask
	task snd(input logic [15:0] w, input logic [1:0] b);
		word <= w;
		bad <= b;
		send <= 1'h1;
		@(posedge core_clk);
		send <= 1'h0;
		repeat (4) @(posedge core_clk);
	endtask
	// eight cycles cover several blink phases with the shortened period
	task look(input logic [6:0] eo, ea);
		lo = '0;
		la = 7'h7F;
		repeat (8)
		begin
			@(posedge core_clk);
			lo |= lamps;
			la &= lamps;
		end
		chk("lamp_or", lo, eo);
		chk("lamp_and", la, ea);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		chk("lamps", lamps, 0);
		bus(0, OFS_FLASH, 0);
		chk("flash", rdat, FLASH_HALF_CYCLES);
		bus(0, OFS_CTRL, 0);
		chk("ctrl", rdat, CTRL_RESET);
		bus(1, OFS_FLASH, 2);
		bus(0, 4'h1, 0);
		chk("unmapped", rdat, READ_UNMAP);
		for (i = 0; i < 4; i++)
		begin
			snd(W[i], 2'(i % 3 + 1));
			look(EO[i], EA[i]);
			chk("update", standby_update_accept, W[i][SW_STANDBY]);
			bus(0, OFS_STATUS, 0);
			chk("voted", rdat[15:0], W[i]);
		end
		slice_healthy <= 3'h5;
		slice_watchdog <= 3'h3;
		repeat (4) @(posedge core_clk);
		chk("green", led_health_green, 3'h5);
		chk("red", led_health_red, 3'h2);
		chk("wdog", led_watchdog, 1);
		slice_watchdog <= 3'h4;
		bus(1, OFS_CTRL, 3);
		repeat (2) @(posedge core_clk);
		chk("wdog", led_watchdog, 0);
		chk("user", {led_user2, led_user1}, 3);
		bus(0, OFS_CTRL, 0);
		chk("ctrl", rdat, 3);
		bus(1, OFS_CTRL, 0);
		for (i = 0; i < 2; i++)
		begin
			{latch_bottom_open, latch_top_open} <= 2'(i + 1);
			repeat (4) @(posedge core_clk);
			chk("irq", proc_irq, 3'h7);
			{latch_bottom_open, latch_top_open} <= 2'h0;
			bus(1, OFS_CTRL, 4);
			repeat (2) @(posedge core_clk);
			chk("irq", proc_irq, 0);
		end
		snd(W[0], 0);
		ejector_open <= 1'h1;
		repeat (4) @(posedge core_clk);
		chk("co", changeover_req, 1);
		ejector_open <= 1'h0;
		snd(W[0] | 16'h1000, 0);
		chk("co", changeover_req, 1);
		snd(W[0], 0);
		chk("co", changeover_req, 0);
		snd(W[1], 0);
		ejector_open <= 1'h1;
		repeat (4) @(posedge core_clk);
		chk("co", changeover_req, 0);
		ejector_open <= 1'h0;
		bus(0, OFS_EVENT, 0);
		chk("events", rdat, 2);
		chk("pulses", pulse_count, 2);
		bus(1, OFS_CTRL, 8);
		bus(0, OFS_EVENT, 0);
		chk("events", rdat, 0);
		finish_test();
	end
	// the sequence needs well under a thousand cycles; this allows twenty thousand
	initial
	begin
		#500000;
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
